//--- rtl/lwcm_crc_lane.v
`timescale 1ns/1ps
`default_nettype none

module lwcm_crc_lane (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire clear,
    input wire [1:0] trigger_code,
    input wire [1:0] recovery_code,
    // multiblock events
    input wire mb_done,
    input wire mb_error,
    // state
    output reg fault
);

    reg [3:0] err_cnt;
    reg [6:0] clean_cnt;
    reg [3:0] trig_th;
    reg [6:0] rec_th;
    wire [3:0] err_inc;
    wire [6:0] clean_inc;

    assign err_inc = (err_cnt == 4'hF) ? err_cnt : err_cnt + 4'h1;
    assign clean_inc = clean_cnt + 7'h01;

    always @* begin
        case (trigger_code)
            2'h0: trig_th = 4'h1;
            2'h1: trig_th = 4'h2;
            2'h2: trig_th = 4'h4;
            default: trig_th = 4'h8;
        endcase
        case (recovery_code)
            2'h0: rec_th = 7'h01;
            2'h1: rec_th = 7'h04;
            2'h2: rec_th = 7'h10;
            default: rec_th = 7'h40;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_cnt <= 4'h0;
            clean_cnt <= 7'h00;
            fault <= 1'b0;
        end else if (clear) begin
            err_cnt <= 4'h0;
            clean_cnt <= 7'h00;
            fault <= 1'b0;
        end else if (mb_done) begin
            if (mb_error) begin
                err_cnt <= err_inc;
                clean_cnt <= 7'h00;
                if (err_inc >= trig_th) begin
                    fault <= 1'b1;
                end
            end else if (clean_inc >= rec_th) begin
                err_cnt <= 4'h0;
                clean_cnt <= 7'h00;
                fault <= 1'b0;
            end else begin
                clean_cnt <= clean_inc;
            end
        end
    end

endmodule // lwcm_crc_lane

`default_nettype wire

//--- rtl/lwcm_regs.vh
`ifndef LWCM_REGS_VH
`define LWCM_REGS_VH

// register indices; byte address is four times the index
`define LWCM_IDX_WATCHDOG_CTRL 12'h124
`define LWCM_IDX_ERROR_PULSE_WIDTH 12'h127
`define LWCM_IDX_CRC_THRESHOLDS 12'h128
`define LWCM_IDX_ARRIVAL_STATUS 12'h12C
`define LWCM_IDX_IRQ_STATUS 12'h170
`define LWCM_IDX_IRQ_MASK 12'h171
`define LWCM_IDX_LINK_CTRL 12'h172
`define LWCM_IDX_ARRIVAL_INDEX 12'h173
`define LWCM_IDX_ARRIVAL_TIME 12'h174
`define LWCM_IDX_CRC_FAULT 12'h175

// reset values
`define LWCM_RST_WATCHDOG_CTRL 8'h80
`define LWCM_RST_ERROR_PULSE_WIDTH 8'h00
`define LWCM_RST_CRC_THRESHOLDS 8'h00
`define LWCM_RST_LINK_CTRL 2'h0
`define LWCM_RST_IRQ 4'h0

// watchdog control fields
`define LWCM_WD_PLL_BIT 7
`define LWCM_WD_DEC_MSB 5
`define LWCM_WD_DEC_LSB 4
`define LWCM_WD_THR_MSB 2
`define LWCM_WD_THR_LSB 0

// error pulse width field
`define LWCM_EPW_MSB 2
`define LWCM_EPW_LSB 0

// crc thresholds fields
`define LWCM_CRC_REC_MSB 3
`define LWCM_CRC_REC_LSB 2
`define LWCM_CRC_TRIG_MSB 1
`define LWCM_CRC_TRIG_LSB 0

// link control fields
`define LWCM_LINK_ENABLE_BIT 0
`define LWCM_LINK_RESET_BIT 1

// interrupt status bits
`define LWCM_IRQ_WATCHDOG 0
`define LWCM_IRQ_CRC_FAULT 1
`define LWCM_IRQ_ARRIVAL 2
`define LWCM_IRQ_SYNC_ERR 3

// watchdog decrement steps per code
`define LWCM_DEC_STEP0 33'h000000001
`define LWCM_DEC_STEP1 33'h000000002
`define LWCM_DEC_STEP2 33'h000000008
`define LWCM_DEC_STEP3 33'h000000010

// watchdog threshold exponents per code 1 to 4
`define LWCM_THR_EXP1 17
`define LWCM_THR_EXP2 19
`define LWCM_THR_EXP3 32
`define LWCM_THR_EXP4 23

`endif

//--- rtl/lwcm_top.v
// Overview of operation
// - on expiry reset the link PLL too when the PLL-reset bit is set; bit resets one
// - link up and no CRC fault: decrement watchdog by step 1, 2, 8 or 16
// - counter reaching threshold resets physical layer, maybe PLL, and restarts counter
// - threshold codes: 0 off, 1-4 give 2^17, 2^19, 2^32, 2^23; 5-7 reserved
// - link-up intervals under 1024 cycles need not affect the watchdog
// - non-resync error asserts SYNC for pulse-width link clock cycles
// - pulse width zero sends no error pulses; legal widths zero to seven
// - recovery code sets error-free run of 1, 4, 16 or 64 multiblocks clearing errors
// - trigger code sets 1, 2, 4 or 8 erroneous multiblocks; each error counts
// - per-lane CRC fault set on reaching trigger count, cleared by an error-free run
// - arrival-ready flag set once arrivals captured on all-ready buffer release attempt
// - arrival-ready flag cleared while link enable low or link reset high
// - arrival times readable only while ready, all from one release attempt
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lwcm_regs.vh"

module lwcm_top #(
    parameter LANES = 16,
    parameter LANE_IDX_W = 4,
    parameter ARR_W = 6,
    parameter THR_EXP1 = `LWCM_THR_EXP1,
    parameter THR_EXP2 = `LWCM_THR_EXP2,
    parameter THR_EXP3 = `LWCM_THR_EXP3,
    parameter THR_EXP4 = `LWCM_THR_EXP4
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // link status from the receiver
    input wire link_up,
    input wire link_clk_tick,
    input wire link_error,
    input wire [LANES-1:0] mb_done,
    input wire [LANES-1:0] mb_crc_error,
    input wire lanes_ready,
    input wire buffer_release_attempt,
    input wire [LANES*ARR_W-1:0] lane_arrival_time,
    // control outputs
    output reg link_enable,
    output reg link_reset_control,
    output reg phy_reset,
    output reg pll_reset,
    output reg sync_n,
    output reg [LANES-1:0] crc_fault,
    output reg irq
);

    reg [7:0] link_watchdog_control;
    reg [7:0] sync_error_pulse_width;
    reg [7:0] crc_error_thresholds;
    reg [6:0] arrival_spare;
    reg arrival_ready_flag;
    reg [LANES*ARR_W-1:0] arrival_cap;
    reg [LANE_IDX_W-1:0] arrival_index;
    reg [3:0] irq_status;
    reg [3:0] irq_mask;
    reg [32:0] wd_count;
    reg [2:0] pulse_left;
    reg [LANES-1:0] fault_prev;

    wire [LANES-1:0] lane_fault;
    wire link_clear;
    wire any_fault;
    wire wr_en;
    wire setup;
    wire [9:0] reg_idx;
    reg [32:0] dec_step;
    reg [32:0] threshold;
    reg wd_enabled;
    reg [31:0] next_rdata;
    reg next_err;
    wire [32:0] next_count;
    wire wd_expire;
    wire [3:0] irq_event;
    wire pulse_start;

    assign link_clear = !link_enable || link_reset_control;
    assign any_fault = |lane_fault;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign reg_idx = paddr[11:2];

    // per-lane CRC alarm
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            lwcm_crc_lane u_lane (
                .pclk(pclk),
                .presetn(presetn),
                .clear(link_clear),
                .trigger_code(crc_error_thresholds[`LWCM_CRC_TRIG_MSB:`LWCM_CRC_TRIG_LSB]),
                .recovery_code(crc_error_thresholds[`LWCM_CRC_REC_MSB:`LWCM_CRC_REC_LSB]),
                .mb_done(mb_done[g]),
                .mb_error(mb_crc_error[g]),
                .fault(lane_fault[g])
            );
        end
    endgenerate

    // watchdog step and threshold decode
    always @* begin
        case (link_watchdog_control[`LWCM_WD_DEC_MSB:`LWCM_WD_DEC_LSB])
            2'h0: dec_step = `LWCM_DEC_STEP0;
            2'h1: dec_step = `LWCM_DEC_STEP1;
            2'h2: dec_step = `LWCM_DEC_STEP2;
            default: dec_step = `LWCM_DEC_STEP3;
        endcase
        wd_enabled = 1'b1;
        case (link_watchdog_control[`LWCM_WD_THR_MSB:`LWCM_WD_THR_LSB])
            3'h1: threshold = 33'h000000001 << THR_EXP1;
            3'h2: threshold = 33'h000000001 << THR_EXP2;
            3'h3: threshold = 33'h000000001 << THR_EXP3;
            3'h4: threshold = 33'h000000001 << THR_EXP4;
            default: begin
                threshold = 33'h000000000;
                wd_enabled = 1'b0;
            end
        endcase
    end

    // single-cycle counting resolves even short link-up intervals
    assign next_count = (!link_up || any_fault) ? wd_count + 33'h000000001 :
        (wd_count < dec_step) ? 33'h000000000 : wd_count - dec_step;
    assign wd_expire = wd_enabled && !link_clear && (wd_count >= threshold);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_count <= 33'h000000000;
            phy_reset <= 1'b0;
            pll_reset <= 1'b0;
        end else begin
            phy_reset <= wd_expire;
            pll_reset <= wd_expire && link_watchdog_control[`LWCM_WD_PLL_BIT];
            if (!wd_enabled || link_clear || wd_expire) begin
                wd_count <= 33'h000000000;
            end else begin
                wd_count <= next_count;
            end
        end
    end

    // error report pulse on SYNC, counted in link clock cycles
    assign pulse_start = link_error && !link_clear &&
        (sync_error_pulse_width[`LWCM_EPW_MSB:`LWCM_EPW_LSB] != 3'h0);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_left <= 3'h0;
            sync_n <= 1'b1;
        end else begin
            if (pulse_start) begin
                pulse_left <= sync_error_pulse_width[`LWCM_EPW_MSB:`LWCM_EPW_LSB];
            end else if (link_clk_tick && pulse_left != 3'h0) begin
                pulse_left <= pulse_left - 3'h1;
            end
            sync_n <= !(pulse_start || (pulse_left > 3'h1) ||
                (pulse_left == 3'h1 && !link_clk_tick));
        end
    end

    // arrival capture; one release attempt fills every lane at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arrival_ready_flag <= 1'b0;
            arrival_cap <= {LANES*ARR_W{1'b0}};
        end else if (link_clear) begin
            arrival_ready_flag <= 1'b0;
        end else if (!arrival_ready_flag && lanes_ready && buffer_release_attempt) begin
            arrival_ready_flag <= 1'b1;
            arrival_cap <= lane_arrival_time;
        end
    end

    // interrupt events, set wins over a write-one clear
    assign irq_event[`LWCM_IRQ_WATCHDOG] = wd_expire;
    assign irq_event[`LWCM_IRQ_CRC_FAULT] = |(lane_fault & ~fault_prev);
    assign irq_event[`LWCM_IRQ_ARRIVAL] = !link_clear && !arrival_ready_flag &&
        lanes_ready && buffer_release_attempt;
    assign irq_event[`LWCM_IRQ_SYNC_ERR] = pulse_start;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `LWCM_RST_IRQ;
            fault_prev <= {LANES{1'b0}};
            crc_fault <= {LANES{1'b0}};
            irq <= 1'b0;
        end else begin
            fault_prev <= lane_fault;
            crc_fault <= lane_fault;
            if (wr_en && reg_idx == `LWCM_IDX_IRQ_STATUS) begin
                irq_status <= (irq_status & ~pwdata[3:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // register read decode
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (reg_idx)
            `LWCM_IDX_WATCHDOG_CTRL: next_rdata[7:0] = link_watchdog_control;
            `LWCM_IDX_ERROR_PULSE_WIDTH: next_rdata[7:0] = sync_error_pulse_width;
            `LWCM_IDX_CRC_THRESHOLDS: next_rdata[7:0] = crc_error_thresholds;
            `LWCM_IDX_ARRIVAL_STATUS: next_rdata[7:0] = {arrival_spare, arrival_ready_flag};
            `LWCM_IDX_IRQ_STATUS: next_rdata[3:0] = irq_status;
            `LWCM_IDX_IRQ_MASK: next_rdata[3:0] = irq_mask;
            `LWCM_IDX_LINK_CTRL: next_rdata[1:0] = {link_reset_control, link_enable};
            `LWCM_IDX_ARRIVAL_INDEX: next_rdata[LANE_IDX_W-1:0] = arrival_index;
            `LWCM_IDX_ARRIVAL_TIME: begin
                if (arrival_ready_flag) begin
                    next_rdata[ARR_W-1:0] = arrival_cap[arrival_index*ARR_W +: ARR_W];
                end
            end
            `LWCM_IDX_CRC_FAULT: next_rdata[LANES-1:0] = lane_fault;
            default: next_err = 1'b1;
        endcase
    end

    // apb answer: ready in the first access cycle, no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && next_err;
            if (setup && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // register writes; settings are meant to change only with the link disabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_watchdog_control <= `LWCM_RST_WATCHDOG_CTRL;
            sync_error_pulse_width <= `LWCM_RST_ERROR_PULSE_WIDTH;
            crc_error_thresholds <= `LWCM_RST_CRC_THRESHOLDS;
            arrival_spare <= 7'h00;
            irq_mask <= `LWCM_RST_IRQ;
            link_enable <= 1'b0;
            link_reset_control <= 1'b0;
            arrival_index <= {LANE_IDX_W{1'b0}};
        end else if (wr_en) begin
            case (reg_idx)
                `LWCM_IDX_WATCHDOG_CTRL: link_watchdog_control <= pwdata[7:0];
                `LWCM_IDX_ERROR_PULSE_WIDTH: sync_error_pulse_width <= pwdata[7:0];
                `LWCM_IDX_CRC_THRESHOLDS: crc_error_thresholds <= pwdata[7:0];
                `LWCM_IDX_ARRIVAL_STATUS: arrival_spare <= pwdata[7:1];
                `LWCM_IDX_IRQ_MASK: irq_mask <= pwdata[3:0];
                `LWCM_IDX_LINK_CTRL: begin
                    link_enable <= pwdata[`LWCM_LINK_ENABLE_BIT];
                    link_reset_control <= pwdata[`LWCM_LINK_RESET_BIT];
                end
                `LWCM_IDX_ARRIVAL_INDEX: arrival_index <= pwdata[LANE_IDX_W-1:0];
                default: arrival_index <= arrival_index;
            endcase
        end
    end

endmodule // lwcm_top

`default_nettype wire

//--- sim/lwcm_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "lwcm_regs.vh"

module lwcm_properties #(
    parameter int LANES = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // link side
    input wire logic link_error,
    input wire logic link_enable,
    input wire logic phy_reset,
    input wire logic pll_reset,
    input wire logic sync_n,
    input wire logic [LANES-1:0] crc_fault
);
    logic wd_pll;
    logic [2:0] wd_thr, epw;
    wire logic wr = psel && penable && pready && pwrite && !pslverr;
    wire logic off = (wd_thr == 3'h0) || (wd_thr > 3'h4);

    // shadows taken at the edge the slave commits a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_pll <= 1'h1;
            wd_thr <= 3'h0;
            epw <= 3'h0;
        end else if (wr && {2'h0, paddr[11:2]} == `LWCM_IDX_WATCHDOG_CTRL) begin
            wd_pll <= pwdata[7];
            wd_thr <= pwdata[2:0];
        end else if (wr && {2'h0, paddr[11:2]} == `LWCM_IDX_ERROR_PULSE_WIDTH) begin
            epw <= pwdata[2:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    a_pll_needs_phy: assert property (pll_reset |-> phy_reset)
        else $error("pll reset without phy reset");
    a_pll_select: assert property (phy_reset |-> pll_reset == $past(wd_pll))
        else $error("pll reset disagrees with enable bit");
    a_expiry_spacing: assert property (phy_reset |=> (!phy_reset) [*8])
        else $error("expiry repeated too soon");
    a_wd_disabled: assert property (off && $past(off) |-> !phy_reset)
        else $error("expiry while watchdog off");
    a_sync_cause: assert property ($fell(sync_n) |-> $past(link_error))
        else $error("sync pulse without error");
    a_sync_zero_width: assert property (
        epw == 3'h0 && $past(epw) == 3'h0 && sync_n |=> sync_n)
        else $error("sync pulse with zero width");
    a_fault_cleared: assert property (!link_enable |=> ##1 (crc_fault == '0))
        else $error("crc fault kept while link cleared");

    c_expiry_pll: cover property (phy_reset && pll_reset);
    c_sync_pulse: cover property ($fell(sync_n));
    c_crc_fault: cover property (|crc_fault);
    c_refused: cover property (pslverr);
endmodule // lwcm_properties

`default_nettype wire

//--- sim/lwcm_xmit_model.sv
`timescale 1ns/1ps
`default_nettype none

module lwcm_xmit_model #(
    parameter int LANES = 4,
    parameter int ARR_W = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic mb_cmd,
    input wire logic [LANES-1:0] bad_cmd,
    input wire logic rdy,
    input wire logic [LANES*ARR_W-1:0] arr_cmd,
    // toward the receiver
    output logic link_clk_tick,
    output logic [LANES-1:0] mb_done,
    output logic [LANES-1:0] mb_crc_error,
    output logic [LANES*ARR_W-1:0] lane_arrival_time
);
    logic [1:0] ph;
    logic [LANES*ARR_W-1:0] junk;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 2'h0;
            junk <= '0;
        end else begin
            ph <= ph + 2'h1;
            junk <= ~junk ^ {LANES*ARR_W{ph[0]}};
        end
    end

    // one link clock cycle spans four pclk
    assign link_clk_tick = (ph == 2'h3);
    assign mb_done = {LANES{mb_cmd}};
    // error flag is only meaningful at a block end, garbage otherwise
    assign mb_crc_error = mb_cmd ? bad_cmd : ~bad_cmd;
    assign lane_arrival_time = rdy ? arr_cmd : junk;
endmodule // lwcm_xmit_model

`default_nettype wire

//--- sim/test_lwcm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lwcm_regs.vh"

module test_lwcm_top;
    localparam int LANES = 4;
    localparam int ARR_W = 6;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, link_enable, link_reset_control, phy_reset, pll_reset;
    logic sync_n, irq, link_clk_tick;
    logic link_up = 1'h0, link_error = 1'h0, lanes_ready = 1'h0, rel = 1'h0, mb_cmd = 1'h0;
    logic [LANES-1:0] bad = '0, mb_done, mb_crc_error, crc_fault;
    logic [LANES*ARR_W-1:0] arr = '0, lane_arrival_time;
    int miscompares = 0, total_checks = 0, c, n;
    int steps[4] = '{1, 2, 8, 16};

    always #5 pclk = ~pclk;

    lwcm_top #(.LANES(LANES), .LANE_IDX_W(2), .ARR_W(ARR_W), .THR_EXP1(4), .THR_EXP2(5),
        .THR_EXP3(6), .THR_EXP4(7)) u_lwcm_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link_up, .link_clk_tick, .link_error,
        .mb_done, .mb_crc_error, .lanes_ready, .buffer_release_attempt(rel), .lane_arrival_time,
        .link_enable, .link_reset_control, .phy_reset, .pll_reset, .sync_n, .crc_fault, .irq);
    lwcm_xmit_model #(.LANES(LANES), .ARR_W(ARR_W)) u_lwcm_xmit_model (.pclk, .presetn,
        .mb_cmd, .bad_cmd(bad), .rdy(lanes_ready), .arr_cmd(arr), .link_clk_tick, .mb_done,
        .mb_crc_error, .lane_arrival_time);

    // thresholds shortened to 2^(code+3) by the parameters above
    function automatic int wd_period(int code, int s);
        if (code < 1 || code > 4) return 1000;
        return (1 << (code + 3)) + 1 + (s > 0 ? s + 1 : 0);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {idx[9:0], 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        if (k >= 16) miscompares++;
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic cfg(input logic [11:0] idx, input logic [31:0] d);
        apb(1'h1, `LWCM_IDX_LINK_CTRL, 32'h0);
        apb(1'h1, idx, d);
        apb(1'h1, `LWCM_IDX_LINK_CTRL, 32'h1);
    endtask

    task automatic wait_exp(input int up_at);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
            link_up <= (c == up_at);
        end while (phy_reset !== 1'h1 && c < 1000);
    endtask

    task automatic mb(input logic [LANES-1:0] m, input int times);
        repeat (times) begin
            @(posedge pclk);
            mb_cmd <= 1'h1;
            bad <= m;
            @(posedge pclk);
            mb_cmd <= 1'h0;
            repeat (2) @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #500000;
        miscompares++;
        conclude();
    end

    initial begin
        void'($urandom(32'h0623));
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `LWCM_IDX_WATCHDOG_CTRL, 32'h0);
        chk(rd, 32'h80, "wd ctrl reset");
        apb(1'h0, `LWCM_IDX_CRC_THRESHOLDS, 32'h0);
        chk(rd, 32'h0, "crc reset");
        chk(sync_n, 1'h1, "sync idle");
        apb(1'h1, 12'h100, 32'hFFFFFFFF);
        chk(er, 1'h1, "unmapped write");
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            logic pl;
            pl = 1'($urandom_range(0, 1));
            cfg(`LWCM_IDX_WATCHDOG_CTRL, {24'h0, pl, 4'h0, k[2:0]});
            wait_exp(-1);
            wait_exp(-1);
            chk(c, wd_period(k, 0), "wd period");
            if (k inside {[1:4]}) chk(pll_reset, pl, "pll reset");
        end
        // one link-up cycle mid count must delay expiry by step plus one
        for (int j = 0; j < 4; j++) begin
            cfg(`LWCM_IDX_WATCHDOG_CTRL, {24'h0, 2'h2, j[1:0], 4'h4});
            wait_exp(-1);
            wait_exp(40);
            chk(c, wd_period(4, steps[j]), "wd step");
        end
        cfg(`LWCM_IDX_WATCHDOG_CTRL, 32'h0);
        $display("test watchdog done");
        for (int w = 0; w < 8; w++) begin
            cfg(`LWCM_IDX_ERROR_PULSE_WIDTH, w);
            link_error <= 1'h1;
            @(posedge pclk);
            link_error <= 1'h0;
            n = 0;
            repeat (60) @(posedge pclk) if (sync_n === 1'h0 && link_clk_tick === 1'h1) n++;
            chk(n, w, "sync ticks");
        end
        apb(1'h0, `LWCM_IDX_IRQ_STATUS, 32'h0);
        chk(rd[`LWCM_IRQ_SYNC_ERR], 1'h1, "sync event");
        chk(irq, 1'h0, "masked irq");
        apb(1'h1, `LWCM_IDX_IRQ_MASK, 32'h8);
        repeat (2) @(posedge pclk);
        chk(irq, 1'h1, "unmasked irq");
        apb(1'h1, `LWCM_IDX_IRQ_STATUS, 32'h8);
        repeat (2) @(posedge pclk);
        chk(irq, 1'h0, "cleared irq");
        $display("test sync done");
        for (int t = 0; t < 4; t++) begin
            logic [LANES-1:0] m;
            m = 4'($urandom_range(1, 15));
            cfg(`LWCM_IDX_CRC_THRESHOLDS, {28'h0, 2'(3 - t), 2'(t)});
            mb(m, (1 << t) - 1);
            chk(crc_fault, '0, "below trigger");
            mb(m, 1);
            chk(crc_fault, m, "at trigger");
            mb('0, (1 << (2 * (3 - t))) - 1);
            chk(crc_fault, m, "short run");
            mb('0, 1);
            chk(crc_fault, '0, "recovered");
        end
        $display("test crc done");
        rd = $urandom;
        arr <= rd[LANES*ARR_W-1:0];
        lanes_ready <= 1'h1;
        n = $urandom_range(0, LANES - 1);
        cfg(`LWCM_IDX_ARRIVAL_INDEX, n);
        c = arr[n*ARR_W +: ARR_W];
        apb(1'h0, `LWCM_IDX_ARRIVAL_STATUS, 32'h0);
        chk(rd[0], 1'h0, "ready before");
        for (int r = 0; r < 2; r++) begin
            rel <= 1'h1;
            @(posedge pclk);
            rel <= 1'h0;
            arr <= ~arr;
            apb(1'h0, `LWCM_IDX_ARRIVAL_STATUS, 32'h0);
            chk(rd[0], 1'h1, "ready after");
            apb(1'h0, `LWCM_IDX_ARRIVAL_TIME, 32'h0);
            chk(rd, c, "arrival");
        end
        apb(1'h1, `LWCM_IDX_LINK_CTRL, 32'h3);
        apb(1'h0, `LWCM_IDX_LINK_CTRL, 32'h0);
        chk(rd, 32'h3, "link ctrl");
        apb(1'h0, `LWCM_IDX_ARRIVAL_STATUS, 32'h0);
        chk(rd[0], 1'h0, "ready cleared");
        apb(1'h0, `LWCM_IDX_ARRIVAL_TIME, 32'h0);
        chk(rd, 32'h0, "hidden time");
        $display("test arrival done");
        conclude();
    end
endmodule // test_lwcm_top

bind lwcm_top lwcm_properties #(.LANES(LANES)) u_lwcm_properties (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .link_error, .link_enable,
    .phy_reset, .pll_reset, .sync_n, .crc_fault);

`default_nettype wire
